// [rtl/ambient_average.v]
// Offset measurement and power-of-two averaging of ambient conversions
`timescale 1ns/1ps
`default_nettype none
`include "ambient_light_regs.vh"

module ambient_average (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Control
    input wire start,
    input wire offset_en,
    input wire [2:0] avg_exp,
    output reg busy,
    output reg done,
    output reg [15:0] result,
    // Converter handshake
    output reg conv_req,
    output reg conv_offset,
    input wire adc_valid,
    input wire [15:0] adc_data
);
    localparam ST_IDLE = 2'd0;
    localparam ST_OFFS = 2'd1;
    localparam ST_CONV = 2'd2;

    reg [1:0] st_q;
    reg [2:0] exp_q;
    reg offs_q;
    reg [15:0] offset_q;
    reg [22:0] acc_q;
    reg [7:0] left_q;
    wire [22:0] acc_d;
    wire [22:0] avg_full;
    wire [15:0] avg;

    assign acc_d = acc_q + {7'h00, adc_data};
    assign avg_full = acc_d >> exp_q;
    assign avg = avg_full[15:0];

    always @(posedge mclk) begin
        if (srst) begin
            st_q <= ST_IDLE;
            exp_q <= 3'h0;
            offs_q <= 1'b0;
            offset_q <= 16'h0000;
            acc_q <= 23'h000000;
            left_q <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            result <= `ALS_RESULT_RESET;
            conv_req <= 1'b0;
            conv_offset <= 1'b0;
        end else begin
            done <= 1'b0;
            conv_req <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        // Settings are frozen for the whole cycle
                        exp_q <= avg_exp;
                        offs_q <= offset_en;
                        offset_q <= 16'h0000;
                        acc_q <= 23'h000000;
                        left_q <= 8'h01 << avg_exp;
                        busy <= 1'b1;
                        conv_req <= 1'b1;
                        conv_offset <= offset_en;
                        st_q <= offset_en ? ST_OFFS : ST_CONV;
                    end
                end
                ST_OFFS: begin
                    if (adc_valid) begin
                        offset_q <= adc_data;
                        conv_req <= 1'b1;
                        conv_offset <= 1'b0;
                        st_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (adc_valid) begin
                        acc_q <= acc_d;
                        left_q <= left_q - 8'h01;
                        if (left_q == 8'h01) begin
                            // Offset above the average clamps to zero, never wraps
                            result <= (avg > offset_q) ? avg - offset_q : 16'h0000;
                            done <= 1'b1;
                            busy <= 1'b0;
                            st_q <= ST_IDLE;
                        end else begin
                            conv_req <= 1'b1;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // ambient_average

`default_nettype wire

// [rtl/ambient_light_regs.vh]
// Register map, field positions, reset values and timing for the ambient light slice
`ifndef AMBIENT_LIGHT_REGS_VH
`define AMBIENT_LIGHT_REGS_VH

// Register addresses
`define ALS_ADDR_PARAM 8'h84
`define ALS_ADDR_RES_HI 8'h85
`define ALS_ADDR_RES_LO 8'h86

// Parameter register fields
`define ALS_CONT_BIT 7
`define ALS_RATE_MSB 6
`define ALS_RATE_LSB 4
`define ALS_OFFS_BIT 3
`define ALS_AVG_MSB 2
`define ALS_AVG_LSB 0

// Reset values: continuous off, 1 sample/s, offset comp on, 32 conversions
`define ALS_PARAM_RESET 8'h0d
`define ALS_RESULT_RESET 16'h0000
`define ALS_READ_UNMAPPED 8'h00

// Serial bus 7-bit device address (value arbitrary)
`define ALS_BUS_ADDR 7'h2a

// Timing: sample rate base period in seconds, clock in Hz
`define ALS_RATE_BASE_S 1
`define ALS_CLK_HZ 25000000

`endif

// [rtl/ambient_light_slice.v]
// Ambient light parameter and result registers behind the two-wire serial bus
// Overview of operation
// - The parameter register sits at address 84h and the host can read and write all fields.
// - Bit 7 turns continuous conversion on when 1 and off when 0, off after reset.
// - With the offset bit set (default) an offset is measured before each reading and subtracted.
// - Averaging value n runs 2 to the n conversions per cycle and reports their average.
// - After reset the averaging field is 101, meaning 32 conversions.
// - Parameter writes during a self-timed run take effect only after the mode is cycled.
// - The 16-bit result shows its upper byte at 85h and lower byte at 86h.
// - Both result bytes are read-only and host writes leave them unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "ambient_light_regs.vh"

module ambient_light_slice #(
    parameter CYC_PER_SEC = `ALS_CLK_HZ * `ALS_RATE_BASE_S
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Two-wire serial bus, open drain
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe,
    // Measurement sequencer links
    input wire selftimed_en,
    input wire ambient_en,
    input wire ambient_single_shot_trigger,
    output reg single_shot_done,
    output reg ambient_ready,
    // Converter handshake
    output wire conv_req,
    output wire conv_offset,
    input wire adc_valid,
    input wire [15:0] adc_data
);
    localparam BS_IDLE = 3'd0;
    localparam BS_ADDR = 3'd1;
    localparam BS_PTR = 3'd2;
    localparam BS_WDATA = 3'd3;
    localparam BS_RDATA = 3'd4;

    reg scl_s1_q, scl_s2_q, scl_s3_q;
    reg sda_s1_q, sda_s2_q, sda_s3_q;
    reg [2:0] bs_q;
    reg [3:0] bit_q;
    reg [7:0] rx_q;
    reg [7:0] tx_q;
    reg [7:0] ptr_q;
    reg rw_q;
    reg nack_q;
    reg [7:0] param_q;
    reg [7:0] active_q;
    reg [15:0] result_q;
    reg [31:0] rate_cnt_q;
    reg trig_q;
    reg cont_run_q;
    reg od_first_q;
    reg start_q;
    wire scl_rise, scl_fall, bus_start, bus_stop;
    wire periodic, eng_busy, eng_done;
    wire [15:0] eng_result;
    wire [7:0] rd_byte;

    // Cycles between periodic samples for a rate code
    function [31:0] rate_period;
        input [2:0] code;
        begin
            case (code)
                3'h0: rate_period = CYC_PER_SEC / 1;
                3'h1: rate_period = CYC_PER_SEC / 2;
                3'h2: rate_period = CYC_PER_SEC / 3;
                3'h3: rate_period = CYC_PER_SEC / 4;
                3'h4: rate_period = CYC_PER_SEC / 5;
                3'h5: rate_period = CYC_PER_SEC / 6;
                3'h6: rate_period = CYC_PER_SEC / 8;
                default: rate_period = CYC_PER_SEC / 10;
            endcase
        end
    endfunction

    function [7:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `ALS_ADDR_PARAM: read_mux = param_q;
                `ALS_ADDR_RES_HI: read_mux = result_q[15:8];
                `ALS_ADDR_RES_LO: read_mux = result_q[7:0];
                default: read_mux = `ALS_READ_UNMAPPED;
            endcase
        end
    endfunction

    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    assign bus_stop = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
    assign periodic = selftimed_en & ambient_en;
    assign rd_byte = read_mux(ptr_q);

    always @(posedge mclk) begin
        if (srst) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // Bus slave: sample on rising clock, change data on falling clock
    always @(posedge mclk) begin
        if (srst) begin
            bs_q <= BS_IDLE;
            bit_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            param_q <= `ALS_PARAM_RESET;
        end else if (bus_start) begin
            bs_q <= BS_ADDR;
            // Clock fall that closes the start is no bit: it wraps the count to 0
            bit_q <= 4'hf;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            bs_q <= BS_IDLE;
            sda_oe <= 1'b0;
        end else if (bs_q != BS_IDLE) begin
            if (scl_rise) begin
                if (bit_q == 4'h8)
                    nack_q <= sda_s2_q;
                else
                    rx_q <= {rx_q[6:0], sda_s2_q};
            end else if (scl_fall) begin
                if (bit_q == 4'h7) begin
                    bit_q <= 4'h8;
                    sda_oe <= 1'b0;
                    case (bs_q)
                        BS_ADDR: begin
                            if (rx_q[7:1] == `ALS_BUS_ADDR) begin
                                rw_q <= rx_q[0];
                                sda_oe <= 1'b1;
                            end else begin
                                bs_q <= BS_IDLE;
                            end
                        end
                        BS_PTR: begin
                            ptr_q <= rx_q;
                            sda_oe <= 1'b1;
                        end
                        BS_WDATA: begin
                            // Result addresses fall through: writes there are dropped
                            if (ptr_q == `ALS_ADDR_PARAM)
                                param_q <= rx_q;
                            ptr_q <= ptr_q + 8'h01;
                            sda_oe <= 1'b1;
                        end
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (bit_q == 4'h8) begin
                    bit_q <= 4'h0;
                    sda_oe <= 1'b0;
                    if ((bs_q == BS_ADDR && rw_q) || (bs_q == BS_RDATA && !nack_q)) begin
                        bs_q <= BS_RDATA;
                        tx_q <= {rd_byte[6:0], 1'b0};
                        sda_oe <= ~rd_byte[7];
                        ptr_q <= ptr_q + 8'h01;
                    end else if (bs_q == BS_RDATA) begin
                        bs_q <= BS_IDLE;
                    end else if (bs_q == BS_ADDR) begin
                        bs_q <= BS_PTR;
                    end else begin
                        bs_q <= BS_WDATA;
                    end
                end else begin
                    bit_q <= bit_q + 4'h1;
                    if (bs_q == BS_RDATA) begin
                        sda_oe <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // Measurement control
    always @(posedge mclk) begin
        if (srst) begin
            active_q <= `ALS_PARAM_RESET;
            rate_cnt_q <= 32'h00000000;
            trig_q <= 1'b0;
            cont_run_q <= 1'b0;
            od_first_q <= 1'b0;
            start_q <= 1'b0;
            result_q <= `ALS_RESULT_RESET;
            single_shot_done <= 1'b0;
            ambient_ready <= 1'b0;
        end else begin
            trig_q <= ambient_single_shot_trigger;
            start_q <= 1'b0;
            single_shot_done <= 1'b0;
            ambient_ready <= 1'b0;
            // Shadow copy frozen while a self-timed run is on
            if (!periodic)
                active_q <= param_q;
            if (!periodic) begin
                rate_cnt_q <= 32'h00000000;
            end else if (rate_cnt_q == 32'h00000000) begin
                start_q <= ~eng_busy;
                rate_cnt_q <= rate_period(active_q[`ALS_RATE_MSB:`ALS_RATE_LSB]) - 1;
            end else begin
                rate_cnt_q <= rate_cnt_q - 32'h00000001;
            end
            if (eng_done) begin
                result_q <= eng_result;
                ambient_ready <= 1'b1;
                single_shot_done <= od_first_q;
                od_first_q <= 1'b0;
                if (cont_run_q && active_q[`ALS_CONT_BIT] && !selftimed_en)
                    start_q <= 1'b1;
            end
            // On-demand only outside self-timed mode; after completion so a new start wins
            if (!selftimed_en && ambient_single_shot_trigger && !trig_q && !eng_busy) begin
                start_q <= 1'b1;
                od_first_q <= 1'b1;
                cont_run_q <= active_q[`ALS_CONT_BIT];
            end
            if (!active_q[`ALS_CONT_BIT] || selftimed_en)
                cont_run_q <= 1'b0;
        end
    end

    ambient_average u_avg (
        .mclk(mclk),
        .srst(srst),
        .start(start_q),
        .offset_en(active_q[`ALS_OFFS_BIT]),
        .avg_exp(active_q[`ALS_AVG_MSB:`ALS_AVG_LSB]),
        .busy(eng_busy),
        .done(eng_done),
        .result(eng_result),
        .conv_req(conv_req),
        .conv_offset(conv_offset),
        .adc_valid(adc_valid),
        .adc_data(adc_data)
    );
endmodule // ambient_light_slice

`default_nettype wire

// [test/ambient_light_slice_checker.sv]
// Port-level assertions for the ambient light slice
`timescale 1ns/1ps
`default_nettype none
module ambient_light_slice_checker (
    // Clock, reset and serial bus
    input wire logic mclk,
    input wire logic srst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Sequencer and converter
    input wire logic selftimed_en,
    input wire logic ambient_en,
    input wire logic ambient_single_shot_trigger,
    input wire logic single_shot_done,
    input wire logic ambient_ready,
    input wire logic conv_req,
    input wire logic conv_offset,
    input wire logic adc_valid,
    input wire logic [15:0] adc_data
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    AST_SDA_LOW_ONLY: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    // Device only grabs the data line while the bus clock is low
    AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("data line grabbed with clock high");
    AST_RESET_QUIET: assert property
        ($fell(srst) |-> !sda_oe && !conv_req && !ambient_ready)
        else $error("activity right after reset");
    AST_READY_AFTER_VALID: assert property (ambient_ready |-> $past(adc_valid, 2))
        else $error("result update without final conversion");
    AST_DONE_WITH_READY: assert property (single_shot_done |-> ambient_ready)
        else $error("on-demand done without result update");
    AST_READY_PULSE: assert property (ambient_ready |=> !ambient_ready)
        else $error("ready longer than one cycle");
    AST_REQ_SPACING: assert property (conv_req |=> !conv_req [*2])
        else $error("request before previous conversion answered");
    AST_OFFSET_THEN_SAMPLE: assert property
        (conv_req && conv_offset |-> ##[1:1000] conv_req && !conv_offset)
        else $error("offset conversion not followed by a sample");
    cover property (single_shot_done);
    cover property (ambient_ready && selftimed_en);
    cover property (conv_req && conv_offset);
endmodule // ambient_light_slice_checker
bind ambient_light_slice ambient_light_slice_checker chk_i (.mclk, .srst, .scl_i, .sda_i,
    .sda_o, .sda_oe, .selftimed_en, .ambient_en, .ambient_single_shot_trigger,
    .single_shot_done, .ambient_ready, .conv_req, .conv_offset, .adc_valid, .adc_data);
`default_nettype wire

// [test/ambient_light_slice_tb.sv]
// Self-checking bench for the ambient light slice
`timescale 1ns/1ps
`default_nettype none
`include "ambient_light_regs.vh"
module ambient_light_slice_tb;
    localparam int CPS = 200;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic selftimed_en = 1'b0;
    logic ambient_en = 1'b0;
    logic ambient_single_shot_trigger = 1'b0;
    logic adc_valid = 1'b0;
    logic [15:0] adc_data = 16'h0000;
    logic [15:0] smp = 16'h1234;
    logic [1:0] wait_c = 2'd0;
    logic off_q = 1'b0;
    logic scl_i, sda_i, sda_o, sda_oe, pull_low, single_shot_done, ambient_ready, conv_req;
    logic conv_offset;
    int conv_cnt = 0;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    always #20 mclk = ~mclk;
    // Pull-up wins unless someone pulls low
    assign sda_i = !(pull_low | sda_oe);
    ambient_light_slice #(.CYC_PER_SEC(CPS)) uut (.mclk, .srst, .scl_i, .sda_i, .sda_o,
        .sda_oe, .selftimed_en, .ambient_en, .ambient_single_shot_trigger, .single_shot_done,
        .ambient_ready, .conv_req, .conv_offset, .adc_valid, .adc_data);
    host_bus_model host (.mclk, .sda_line(sda_i), .scl(scl_i), .pull_low);
    // Converter stand-in answers three cycles after each request
    always @(negedge mclk) begin
        if (conv_req) begin
            wait_c <= 2'd2;
            off_q <= conv_offset;
            conv_cnt <= conv_cnt + 1;
        end else if (wait_c != 2'd0) begin
            wait_c <= wait_c - 2'd1;
        end
        adc_valid <= !conv_req && wait_c == 2'd1;
        adc_data <= (!conv_req && wait_c == 2'd1) ? (off_q ? 16'h0010 : smp) : ~adc_data;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic a0, a1, a2;
        host.start();
        host.put({`ALS_BUS_ADDR, 1'b0}, a0);
        host.put(ptr, a1);
        host.put(d, a2);
        host.stop();
        chk("write ack", 16'h0007, {a0, a1, a2});
    endtask
    // Two-byte burst from ptr
    task automatic rd(input logic [7:0] ptr, output logic [15:0] v);
        logic a0, a1, a2;
        host.start();
        host.put({`ALS_BUS_ADDR, 1'b0}, a0);
        host.put(ptr, a1);
        host.start();
        host.put({`ALS_BUS_ADDR, 1'b1}, a2);
        host.get(1'b0, v[15:8]);
        host.get(1'b1, v[7:0]);
        host.stop();
        chk("read ack", 16'h0007, {a0, a1, a2});
    endtask
    task automatic wait_ready(input logic ss, output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (ambient_ready !== 1'b1 && n < 3000);
        chk("ready seen", 16'h0001, ambient_ready);
        chk("single done", ss, single_shot_done);
    endtask
    task automatic shot(input logic [7:0] p, input int convs, input logic [15:0] res);
        int n, c0;
        logic [15:0] v;
        wr(`ALS_ADDR_PARAM, p);
        c0 = conv_cnt;
        ambient_single_shot_trigger = 1'b1;
        wait_ready(1'b1, n);
        ambient_single_shot_trigger = 1'b0;
        chk("conversions", convs, conv_cnt - c0);
        rd(`ALS_ADDR_RES_HI, v);
        chk("result", res, v);
    endtask
    initial begin
        logic [15:0] v;
        int n, c0;
        int divs[8] = '{1, 2, 3, 4, 5, 6, 8, 10};
        repeat (12) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        rd(`ALS_ADDR_PARAM, v);
        chk("param reset", 16'h0d00, v);
        rd(`ALS_ADDR_RES_LO, v);
        chk("result reset", 16'h0000, v);
        for (int i = 0; i < 8; i++) shot({5'h00, i[2:0]}, 1 << i, 16'h1234);
        smp = 16'h0008;
        shot(8'h08, 2, 16'h0000);
        smp = 16'h1234;
        shot(8'h0d, 33, 16'h1224);
        wr(`ALS_ADDR_RES_HI, 8'hff);
        wr(`ALS_ADDR_RES_LO, 8'hff);
        rd(`ALS_ADDR_RES_HI, v);
        chk("read-only result", 16'h1224, v);
        wr(`ALS_ADDR_PARAM, 8'hfa);
        rd(`ALS_ADDR_PARAM, v);
        chk("param readback", 16'hfa12, v);
        // Continuous mode restarts back to back until the bit is cleared
        wr(`ALS_ADDR_PARAM, 8'h80);
        ambient_single_shot_trigger = 1'b1;
        wait_ready(1'b1, n);
        ambient_single_shot_trigger = 1'b0;
        c0 = conv_cnt;
        wait_ready(1'b0, n);
        chk("continuous restart", 16'h0001, n < 20);
        chk("continuous convs", 1, conv_cnt - c0);
        wr(`ALS_ADDR_PARAM, 8'h00);
        repeat (20) @(negedge mclk);
        c0 = conv_cnt;
        repeat (40) @(negedge mclk);
        chk("continuous stopped", 0, conv_cnt - c0);
        for (int r = 0; r < 8; r++) begin
            wr(`ALS_ADDR_PARAM, {1'b0, r[2:0], 4'h0});
            selftimed_en = 1'b1;
            ambient_en = 1'b1;
            wait_ready(1'b0, n);
            wait_ready(1'b0, n);
            chk("rate period", CPS / divs[r], n);
            selftimed_en = 1'b0;
            ambient_en = 1'b0;
        end
        // Deliberate write during a self-timed run
        selftimed_en = 1'b1;
        ambient_en = 1'b1;
        wr(`ALS_ADDR_PARAM, 8'h08);
        wait_ready(1'b0, n);
        c0 = conv_cnt;
        wait_ready(1'b0, n);
        chk("frozen settings", 1, conv_cnt - c0);
        selftimed_en = 1'b0;
        @(negedge mclk);
        selftimed_en = 1'b1;
        wait_ready(1'b0, n);
        c0 = conv_cnt;
        wait_ready(1'b0, n);
        chk("settings after cycling", 2, conv_cnt - c0);
        finish_test();
    end
endmodule // ambient_light_slice_tb
`default_nettype wire

// [test/host_bus_model.sv]
// Two-wire bus host model
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock and bus lines
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic pull_low
);
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // Six cycles keeps every phase above the four-cycle minimum
    task automatic half();
        repeat (6) @(negedge mclk);
    endtask
    // Works from idle and as a repeated start
    task automatic start();
        pull_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        pull_low = 1'b1;
        half();
        scl = 1'b0;
        half();
    endtask
    task automatic stop();
        pull_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        pull_low = 1'b0;
        half();
    endtask
    task automatic slot(input logic b, output logic s);
        pull_low = !b;
        half();
        scl = 1'b1;
        half();
        s = sda_line;
        scl = 1'b0;
        half();
    endtask
    task automatic put(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(v[i], s);
        slot(1'b1, s);
        ack = !s;
    endtask
    task automatic get(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) slot(1'b1, v[i]);
        slot(last, s);
    endtask
endmodule // host_bus_model
`default_nettype wire
